/* File: lan_arbiter_model.sv */
// Bus arbiter stand-in granting after a chosen delay
`timescale 1ns/1ps
module lan_arbiter_model (
	input  wire logic       clock,         // Clock
	input  wire logic       nrst,          // Reset, active low
	input  wire logic       busRequestOut, // Request from device
	input  wire logic [3:0] grantDelay,    // Cycles before grant
	output logic            busGrant       // Grant to device
);
	logic [3:0] waitCnt;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			busGrant <= 1'b0;
			waitCnt  <= 4'h0;
		end else if (!busRequestOut) begin
			busGrant <= 1'b0;
			waitCnt  <= 4'h0;
		end else if (waitCnt >= grantDelay) begin
			busGrant <= 1'b1;
		end else begin
			waitCnt <= waitCnt + 4'h1;
		end
	end
endmodule

/* File: lan_ctrl_bus_dma_handshake.sv */
// Bus request, grant, remote DMA pin, latch handshakes and interrupt
`timescale 1ns/1ps
`include "lan_dma_defines.svh"

// Function
// [R1] Long address mode: shared pin strobes upper address bits from remote start regs. Code leaves the pin undriven during the first T1 of each burst.
// [R2] Upper address strobe stays undriven until bus grant arrives.
// [R3] Short address mode: shared pin requests one remote DMA transfer.
// [R4] Remote DMA request is always driven as plain logic output.
// [R5] Shared pin undriven after reset until data configuration is written.
// [R6] Bus grant is active high and gives the device bus ownership.
// [R7] Bus request rises by itself when FIFO needs service.
// [R8] Host must never hold grant permanently high.
// [R9] Reset stops transmit and receive until start bit is set.
// [R10] Reset clears command, mask, data and transmit configuration.
// [R11] Reset completes within ten bus clock cycles.
// [R12] Interrupt raised on reception, transmission or DMA completion.
// [R13] Interrupt status cleared by write; every source individually maskable.
// [R14] Write acknowledge starts a local memory write cycle.
// [R15] Read acknowledge starts a read cycle to refill latch.
// [R16] Latch load strobe rises while valid read data is on bus.
// [R17] DMA cycle takes four clocks, ready stretches by single clocks.
// [R18] Request drops after burst; bus released when grant withdrawn.
module lan_ctrl_bus_dma_handshake (
	input  wire logic        clock,         // 100 MHz bus clock
	input  wire logic        nrst,          // Async reset, active low
	input  wire logic        psel,          // APB select
	input  wire logic        penable,       // APB enable
	input  wire logic        pwrite,        // APB direction
	input  wire logic [11:0] paddr,         // APB byte address
	input  wire logic [31:0] pwdata,        // APB write data
	output logic      [31:0] prdata,        // APB read data
	output logic             pready,        // APB ready
	output logic             pslverr,       // APB error
	input  wire logic        fifoNeedsService, // FIFO wants DMA
	input  wire logic        rxDone,        // Packet received pulse
	input  wire logic        txDone,        // Packet sent pulse
	input  wire logic        busGrant,      // Bus grant pin
	input  wire logic        latchWriteAck, // Latch write acknowledge pin
	input  wire logic        latchReadAck,  // Latch read acknowledge pin
	input  wire logic        memReady,      // Wait-state request pin
	output logic             busRequestOut, // Bus request pin
	output logic             dualPinOut,    // Shared request/strobe level
	output logic             dualPinOe,     // Shared pin output enable
	output logic             latchLoadStrobe, // Latch load strobe pin
	output logic             memCycleWrite, // Active DMA cycle is a write
	output logic             busOwned,      // Device holds the bus
	output logic [15:0]      upperAddr,     // Upper address bits for latch
	output logic             irq,           // Interrupt, active high
	output logic             macEnable      // Transmit/receive allowed
);
	import lan_dma_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	reg_byte_t  cmdReg;
	reg_byte_t  imrReg;
	reg_byte_t  dcrReg;
	reg_byte_t  tcrReg;
	reg_byte_t  rsaLo;
	reg_byte_t  rsaHi;
	logic [2:0] isrReg;
	logic       dcrWritten;
	logic [3:0] resetCount;
	logic       resetDone;
	dma_state_e state;
	dma_state_e next_state;
	logic       cycleIsWrite;
	logic       strobePhase;
	logic       pendWrite;
	logic       pendRead;
	logic       burstDone;
	logic [2:0] pinSync;
	logic       grantS;
	logic       wackS;
	logic       rackS;
	logic       wackD;
	logic       rackD;
	logic       wrAccess;
	logic       longAddr;
	logic [2:0] setBits;
	logic [2:0] clrBits;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction

	pin_sync #(
		.WIDTH(3)
	) u_sync (
		.clock(clock),
		.nrst (nrst),
		.din  ({busGrant, latchWriteAck, latchReadAck}),
		.dout (pinSync)
	);
	assign grantS = pinSync[2];
	assign wackS  = pinSync[1];
	assign rackS  = pinSync[0];

	////////////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states
	assign pready   = 1'b1;
	assign wrAccess = psel && penable && pwrite;
	assign longAddr = dcrReg[`DCR_LAS_BIT];

	always_comb begin
		pslverr = 1'b0;
		if (psel && penable) begin
			pslverr = !(hit(paddr, `REG_CMD) || hit(paddr, `REG_ISR) ||
				hit(paddr, `REG_IMR) || hit(paddr, `REG_DCR) ||
				hit(paddr, `REG_TCR) || hit(paddr, `REG_RSA_LO) ||
				hit(paddr, `REG_RSA_HI) || hit(paddr, `REG_STATUS) ||
				hit(paddr, `REG_EVENT));
		end
	end

	// Reset clears the configuration set
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cmdReg <= `CMD_RESET; // [R10]
			imrReg <= `IMR_RESET; // [R10]
			dcrReg <= `DCR_RESET; // [R10]
			tcrReg <= `TCR_RESET; // [R10]
			rsaLo  <= 8'h00;
			rsaHi  <= 8'h00;
		end else if (wrAccess && resetDone) begin
			if (hit(paddr, `REG_CMD))
				cmdReg <= pwdata[7:0];
			if (hit(paddr, `REG_IMR))
				imrReg <= pwdata[7:0];
			if (hit(paddr, `REG_DCR))
				dcrReg <= pwdata[7:0];
			if (hit(paddr, `REG_TCR))
				tcrReg <= pwdata[7:0];
			if (hit(paddr, `REG_RSA_LO))
				rsaLo <= pwdata[7:0];
			if (hit(paddr, `REG_RSA_HI))
				rsaHi <= pwdata[7:0];
		end
	end

	// Shared pin stays off the bus until configured
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dcrWritten <= 1'b0;
		end else if (wrAccess && resetDone && hit(paddr, `REG_DCR)) begin
			dcrWritten <= 1'b1; // [R5]
		end
	end

	// Internal reset sequencing
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			resetCount <= 4'h0;
		end else if (!resetDone) begin
			resetCount <= resetCount + 4'h1; // [R11]
		end
	end
	assign resetDone = (resetCount == 4'(`RESET_CYCLES - 1));
	assign macEnable = resetDone && cmdReg[`CMD_START_BIT]; // [R9]

	always_comb begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite) begin
			if (hit(paddr, `REG_CMD))
				prdata = {24'h0, cmdReg};
			else if (hit(paddr, `REG_ISR))
				prdata = {29'h0, isrReg};
			else if (hit(paddr, `REG_IMR))
				prdata = {24'h0, imrReg};
			else if (hit(paddr, `REG_DCR))
				prdata = {24'h0, dcrReg};
			else if (hit(paddr, `REG_TCR))
				prdata = {24'h0, tcrReg};
			else if (hit(paddr, `REG_RSA_LO))
				prdata = {24'h0, rsaLo};
			else if (hit(paddr, `REG_RSA_HI))
				prdata = {24'h0, rsaHi};
			else if (hit(paddr, `REG_STATUS))
				prdata = {24'h0, 2'b00, state};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status, set wins over clear-by-write-one
	assign setBits = {burstDone, txDone && macEnable, rxDone && macEnable}; // [R12]
	assign clrBits = (wrAccess && hit(paddr, `REG_ISR)) ? pwdata[2:0] : 3'b000;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			isrReg <= 3'b000;
		end else begin
			isrReg <= (isrReg & ~clrBits) | setBits; // [R13]
		end
	end
	assign irq = |(isrReg & imrReg[2:0]); // [R13]

	////////////////////////////////////////////////////////////////////////////
	// Latch acknowledge edges queue memory cycles
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wackD <= 1'b0;
			rackD <= 1'b0;
		end else begin
			wackD <= wackS;
			rackD <= rackS;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pendWrite <= 1'b0;
			pendRead  <= 1'b0;
		end else begin
			if (wackS && !wackD)
				pendWrite <= 1'b1; // [R14]
			else if (state == DMA_T1 && cycleIsWrite)
				pendWrite <= 1'b0;
			if (rackS && !rackD)
				pendRead <= 1'b1; // [R15]
			else if (state == DMA_T1 && !cycleIsWrite)
				pendRead <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus ownership and four-clock memory cycle
	always_comb begin
		next_state = state;
		unique case (state)
			DMA_IDLE:
				// Wait for the old grant to drop so a stale grant is never reused
				if (resetDone && !grantS && (fifoNeedsService || pendWrite || pendRead))
					next_state = DMA_REQ; // [R7] [R18]
			DMA_REQ:
				if (grantS)
					next_state = DMA_T1; // [R6]
			DMA_T1:
				next_state = DMA_T2; // [R17]
			DMA_T2:
				next_state = DMA_T3;
			DMA_T3:
				if (!memReady)
					next_state = DMA_T4; // [R17]
			DMA_T4:
				if (!grantS || !(fifoNeedsService || pendWrite || pendRead))
					next_state = DMA_IDLE; // [R18]
				else
					next_state = DMA_T1;
			default:
				next_state = DMA_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= DMA_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cycleIsWrite <= 1'b0;
		end else if (next_state == DMA_T1) begin
			cycleIsWrite <= pendWrite; // [R14]
		end
	end

	assign burstDone     = (state == DMA_T4) && (next_state == DMA_IDLE);
	assign busRequestOut = (state != DMA_IDLE); // [R7] [R18]
	assign busOwned      = (state != DMA_IDLE) && (state != DMA_REQ) && grantS; // [R18]
	assign memCycleWrite = cycleIsWrite;

	// Latch strobe low in T3/T4, rising as T4 ends with data valid
	assign strobePhase = !cycleIsWrite && (state == DMA_T2 || state == DMA_T3);
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			latchLoadStrobe <= 1'b1;
		end else begin
			latchLoadStrobe <= !strobePhase; // [R16]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared request/strobe pin
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dualPinOut <= 1'b0;
			dualPinOe  <= 1'b0;
			upperAddr  <= 16'h0000;
		end else if (!dcrWritten) begin
			dualPinOe  <= 1'b0; // [R5]
			dualPinOut <= 1'b0;
		end else if (longAddr) begin
			upperAddr  <= {rsaHi, rsaLo}; // [R1]
			dualPinOe  <= busOwned; // [R2]
			dualPinOut <= (next_state == DMA_T1); // [R1]
		end else begin
			dualPinOe  <= 1'b1; // [R4]
			dualPinOut <= (pendWrite || pendRead) && (state == DMA_IDLE); // [R3]
		end
	end
endmodule

/* File: lan_ctrl_bus_dma_handshake_tb_top.sv */
// Self-checking bench for the bus handshake block
`timescale 1ns/1ps
`include "lan_dma_defines.svh"
module lan_ctrl_bus_dma_handshake_tb_top;
	logic        clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, r;
	logic        pready, pslverr, err, fifoNeedsService = 1'b0, rxDone = 1'b0, txDone = 1'b0;
	logic        busGrant, latchWriteAck = 1'b0, latchReadAck = 1'b0, memReady = 1'b0;
	logic        busRequestOut, dualPinOut, dualPinOe, latchLoadStrobe, memCycleWrite;
	logic        busOwned, irq, macEnable;
	logic [15:0] upperAddr;
	logic [3:0]  grantDelay = 4'h1;
	int          bad_count = 0, cmp_count = 0, seed = 32'h6b85, n;
	always #5 clock = ~clock;
	lan_ctrl_bus_dma_handshake lan_ctrl_bus_dma_handshake_inst (.*);
	lan_arbiter_model lan_arbiter_model_inst (.*);
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic waitUp(ref logic s, input logic v);
		for (int i = 0; s !== v; i++) begin
			if (i == 200) begin
				bad_count++;
				conclude();
			end
			@(posedge clock);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		waitUp(pready, 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic doReset;
		logic [11:0] a[4];
		nrst <= 1'b0;
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		repeat (10) @(posedge clock);
		a = '{`REG_CMD, `REG_IMR, `REG_DCR, `REG_TCR};
		foreach (a[k]) begin
			apb(a[k], 1'b0, 32'h0);
			chk(rd, 32'h0);
		end
		chk(macEnable, 1'b0);
		chk(dualPinOe, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		doReset();
		apb(12'h040, 1'b0, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		r = $random(seed);
		apb(`REG_TCR, 1'b1, 32'hA5);
		apb(`REG_IMR, 1'b1, r & 32'h7);
		apb(`REG_CMD, 1'b1, 32'h1);
		chk(macEnable, 1'b1);
		rxDone <= 1'b1;
		txDone <= 1'b1;
		@(posedge clock);
		rxDone <= 1'b0;
		txDone <= 1'b0;
		repeat (2) @(posedge clock);
		chk(irq, |r[1:0]);
		apb(`REG_ISR, 1'b0, 32'h0);
		chk(rd[1:0], 2'b11);
		apb(`REG_ISR, 1'b1, 32'h7);
		chk(irq, 1'b0);
		fifoNeedsService <= 1'b1;
		waitUp(busRequestOut, 1'b1);
		waitUp(busOwned, 1'b1);
		fifoNeedsService <= 1'b0;
		waitUp(busRequestOut, 1'b0);
		apb(`REG_ISR, 1'b0, 32'h0);
		chk(rd[2], 1'b1);
		grantDelay <= 4'h9;
		apb(`REG_DCR, 1'b1, 32'h0);
		@(posedge clock);
		chk(dualPinOe, 1'b1);
		for (n = 0; n < 4; n++) begin
			memReady <= n[0];
			latchReadAck <= 1'b1;
			repeat (6) @(posedge clock);
			latchReadAck <= 1'b0;
			waitUp(latchLoadStrobe, 1'b0);
			memReady <= 1'b0;
			latchWriteAck <= 1'b1;
			repeat (6) @(posedge clock);
			latchWriteAck <= 1'b0;
			waitUp(memCycleWrite, 1'b1);
			waitUp(busRequestOut, 1'b0);
		end
		r = $random(seed);
		apb(`REG_RSA_LO, 1'b1, {24'h0, r[7:0]});
		apb(`REG_RSA_HI, 1'b1, {24'h0, r[15:8]});
		apb(`REG_DCR, 1'b1, 32'h1);
		repeat (2) @(posedge clock);
		chk(upperAddr, r[15:0]);
		chk(dualPinOe, 1'b0);
		fifoNeedsService <= 1'b1;
		waitUp(busOwned, 1'b1);
		fifoNeedsService <= 1'b0;
		waitUp(busRequestOut, 1'b0);
		doReset();
		conclude();
	end
endmodule

/* File: lan_dma_defines.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef LAN_DMA_DEFINES_SVH
`define LAN_DMA_DEFINES_SVH
`define REG_CMD          12'h000
`define REG_ISR          12'h004
`define REG_IMR          12'h008
`define REG_DCR          12'h00C
`define REG_TCR          12'h010
`define REG_RSA_LO       12'h014
`define REG_RSA_HI       12'h018
`define REG_STATUS       12'h01C
`define REG_EVENT        12'h020
`define CMD_START_BIT    0
`define DCR_LAS_BIT      0
`define ISR_RX_BIT       0
`define ISR_TX_BIT       1
`define ISR_DMA_BIT      2
`define CMD_RESET        8'h00
`define IMR_RESET        8'h00
`define DCR_RESET        8'h00
`define TCR_RESET        8'h00
`define RESET_CYCLES     10
`define DMA_CYCLE_CLOCKS 4
`endif

/* File: lan_dma_pkg.sv */
// Types shared by the bus-handshake block
package lan_dma_pkg;
	typedef enum logic [5:0] {
		DMA_IDLE  = 6'b000001,
		DMA_REQ   = 6'b000010,
		DMA_T1    = 6'b000100,
		DMA_T2    = 6'b001000,
		DMA_T3    = 6'b010000,
		DMA_T4    = 6'b100000
	} dma_state_e;
	typedef logic [7:0] reg_byte_t;
endpackage

/* File: lan_dma_props.sv */
// Port-level checker for the bus handshake block
`timescale 1ns/1ps
`include "lan_dma_defines.svh"
module lan_dma_props (
	input wire logic        clock,            // Clock
	input wire logic        nrst,             // Reset, active low
	input wire logic        psel,             // APB
	input wire logic        penable,          // APB
	input wire logic        pwrite,           // APB
	input wire logic [11:0] paddr,            // APB
	input wire logic [31:0] pwdata,           // APB
	input wire logic        fifoNeedsService, // FIFO
	input wire logic        busGrant,         // Grant
	input wire logic        latchWriteAck,    // Ack
	input wire logic        latchReadAck,     // Ack
	input wire logic        memReady,         // Wait
	input wire logic        busRequestOut,    // Request
	input wire logic        dualPinOe,        // Enable
	input wire logic        dualPinOut,       // Shared pin level
	input wire logic        latchLoadStrobe,  // Strobe
	input wire logic        memCycleWrite,    // Write cycle
	input wire logic        busOwned,         // Owner
	input wire logic        irq,              // Interrupt
	input wire logic        macEnable         // Run
);
	logic wr;
	logic dcrSeen;
	logic longMode;
	logic maskAny;
	logic startSeen;
	assign wr = psel && penable && pwrite;
	// Shadow of the configuration written so far
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dcrSeen   <= 1'b0;
			longMode  <= 1'b0;
			maskAny   <= 1'b0;
			startSeen <= 1'b0;
		end else if (wr) begin
			if (paddr == `REG_DCR) begin
				dcrSeen  <= 1'b1;
				longMode <= pwdata[0];
			end
			if (paddr == `REG_IMR) maskAny <= |pwdata[2:0];
			if (paddr == `REG_CMD) startSeen <= pwdata[0];
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	sequence readStrobe;
		$fell(latchLoadStrobe) && !memReady;
	endsequence
	chk_oe_before_cfg: assert property (!dcrSeen |-> !dualPinOe)
		else $error("shared pin driven before configuration");
	chk_strobe_grant: assert property (longMode && $past(longMode) && dualPinOe |-> $past(busRequestOut))
		else $error("address strobe driven without bus");
	chk_req_rise: assert property (macEnable && fifoNeedsService && !busRequestOut |-> ##[1:2] busRequestOut)
		else $error("bus request missing");
	chk_grant_first: assert property (!busGrant [*7] |-> !busOwned)
		else $error("bus owned without grant");
	chk_read_len: assert property (readStrobe |=> !latchLoadStrobe ##1 latchLoadStrobe)
		else $error("read strobe length wrong");
	chk_read_ack: assert property ($rose(latchReadAck) |-> ##[3:60] $fell(latchLoadStrobe))
		else $error("no read cycle after read ack");
	chk_write_ack: assert property ($rose(latchWriteAck) |-> ##[3:60] busOwned && memCycleWrite)
		else $error("no write cycle after write ack");
	chk_mask_quiet: assert property (!maskAny |-> !irq)
		else $error("interrupt with all sources masked");
	chk_start_gate: assert property (macEnable == startSeen)
		else $error("mac enable disagrees with start");
	chk_addr_strobe: assert property (longMode && $past(longMode) && $rose(busOwned) |-> dualPinOut)
		else $error("no upper address strobe at cycle start");
	chk_short_drive: assert property (dcrSeen && !longMode && $past(dcrSeen) && $past(!longMode) |=> dualPinOe)
		else $error("request pin not driven in short mode");
endmodule
bind lan_ctrl_bus_dma_handshake lan_dma_props lan_dma_props_inst (.*);

/* File: pin_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock, // System clock
	input  wire logic             nrst,  // Async reset, active low
	input  wire logic [WIDTH-1:0] din,   // Asynchronous pins
	output logic      [WIDTH-1:0] dout   // Filtered level
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					dout[i] <= 1'b0;
				end else if (s2[i] == s3[i]) begin
					dout[i] <= s2[i];
				end
			end
		end
	endgenerate
endmodule
